// ==== rls_regs.svh ====
// timing counts, field positions and constant patterns of the serializer bridge
`ifndef RLS_REGS_SVH
`define RLS_REGS_SVH

// ----------------------------------------------------------------
// pixel word layout
// ----------------------------------------------------------------
`define RLS_WORD_W 28
`define RLS_LANE_BITS 7
`define RLS_LANES 4
`define RLS_HSYNC_POS 18
`define RLS_VSYNC_POS 19
`define RLS_VALID_POS 20
`define RLS_MODE_SINGLE 1'b0
`define RLS_EDGE_RISING 1'b1
// four bit times high, three low; bit 0 leaves first
`define RLS_CLK_PATTERN 7'h63

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RLS_SYS_CLK_MHZ 100
`define RLS_LOCK_TIME_MS 1
`define RLS_LOCK_CYCLES (`RLS_LOCK_TIME_MS * 1000 * `RLS_SYS_CLK_MHZ)
`define RLS_PD_DELAY_NS 100
`define RLS_PD_DELAY_CYCLES (`RLS_PD_DELAY_NS * `RLS_SYS_CLK_MHZ / 1000)
`define RLS_IDLE_CYCLES 5'h10
`define RLS_DUAL_LAT_PCLK 9
`define RLS_DUAL_DLY_DEPTH (`RLS_DUAL_LAT_PCLK - 2)

`endif

// ==== rls_pkg.sv ====
// types shared by the serializer bridge
package rls_pkg;
	typedef enum logic [2:0] {
		RLS_SLEEP = 3'b001,
		RLS_LOCKING = 3'b010,
		RLS_ACTIVE = 3'b100
	} rls_pll_state_e;

	typedef logic [27:0] rls_word_t;
endpackage : rls_pkg

// ==== rls_sync2.sv ====
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module rls_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule : rls_sync2
`default_nettype wire

// ==== rls_serializer.sv ====
// parallel rgb to lvds frame serializer: pll lock control and pixel framing
`timescale 1ns/1ps
`default_nettype none
`include "rls_regs.svh"
module rls_serializer import rls_pkg::*; #(
	parameter int unsigned LOCK_CYCLES = `RLS_LOCK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_pix_i,
	input wire logic pixel_mode_select_i,
	input wire logic sample_edge_select_i,
	input wire logic powerdown_active_low_i,
	input wire logic [27:0] pixel_data_i,
	input wire logic horizontal_sync_i,
	input wire logic vertical_sync_i,
	input wire logic pixel_valid_flag_i,
	output logic [27:0] lane_set_a_o,
	output logic [27:0] lane_set_b_o,
	output logic [6:0] lane_a_clock_out_o,
	output logic [6:0] lane_b_clock_out_o,
	output logic frame_load_o,
	output logic lane_a_enable_o,
	output logic lane_b_enable_o,
	output logic pll_locked_o
);
	localparam int DEPTH = `RLS_DUAL_DLY_DEPTH;

	// ----------------------------------------------------------------
	// system domain: powerdown, clock presence, lock timer
	// ----------------------------------------------------------------
	logic [2:0] sys_s;
	logic pd_s, mode_sys_s, hb_s;
	logic hb_pix_q;
	logic hb_prev_q, hb_prev_d;
	logic [4:0] idle_q, idle_d;
	logic [16:0] lock_cnt_q, lock_cnt_d;
	rls_pll_state_e state_q, state_d;
	logic clk_seen;

	rls_sync2 #(.WIDTH(3)) u_sync_sys (
		.clk_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i({hb_pix_q, pixel_mode_select_i, powerdown_active_low_i}),
		.sync_o(sys_s)
	);
	assign hb_s = sys_s[2];
	assign mode_sys_s = sys_s[1];
	assign pd_s = sys_s[0];

	// pixel clock counts as running while its heartbeat keeps toggling
	assign clk_seen = (idle_q != `RLS_IDLE_CYCLES);

	always_comb begin
		hb_prev_d = hb_s;
		idle_d = (hb_s != hb_prev_q) ? 5'h00 : (clk_seen ? idle_q + 5'h01 : idle_q);
		state_d = state_q;
		lock_cnt_d = 17'h00000;
		unique case (state_q)
			RLS_SLEEP: begin
				if (pd_s && clk_seen) state_d = RLS_LOCKING;
			end
			RLS_LOCKING: begin
				lock_cnt_d = lock_cnt_q + 17'h00001;
				if (!pd_s || !clk_seen) state_d = RLS_SLEEP;
				else if (lock_cnt_q == 17'(LOCK_CYCLES - 1)) state_d = RLS_ACTIVE;
			end
			RLS_ACTIVE: begin
				// a stopped pixel clock also drops lock, as the pll would
				if (!pd_s || !clk_seen) state_d = RLS_SLEEP;
			end
			default: state_d = RLS_SLEEP;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= RLS_SLEEP;
			lock_cnt_q <= 17'h00000;
			hb_prev_q <= 1'b0;
			idle_q <= `RLS_IDLE_CYCLES;
		end else begin
			state_q <= state_d;
			lock_cnt_q <= lock_cnt_d;
			hb_prev_q <= hb_prev_d;
			idle_q <= idle_d;
		end
	end

	// drivers follow the state directly, not through the pixel domain
	assign pll_locked_o = (state_q == RLS_ACTIVE);
	assign lane_a_enable_o = pll_locked_o;
	assign lane_b_enable_o = pll_locked_o && mode_sys_s;

	sleep_entry_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!pd_s |=> state_q == RLS_SLEEP) else $error("not asleep after powerdown");
	pd_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(pd_s) |=> !lane_a_enable_o && !lane_b_enable_o)
		else $error("drivers still on after powerdown");
	lock_time_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(pll_locked_o) |-> $past(lock_cnt_q) == 17'(LOCK_CYCLES - 1))
		else $error("lock reported before lock time");
	b_enable_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		lane_b_enable_o |-> lane_a_enable_o && mode_sys_s)
		else $error("set b on outside dual mode");

	// ----------------------------------------------------------------
	// pixel domain: capture, pixel split, framing
	// ----------------------------------------------------------------
	logic [2:0] pix_s;
	logic lock_pix, mode_pix, edge_pix;
	rls_word_t fall_q, raw_word;
	rls_word_t cap_q, cap_d;
	rls_word_t pipe_q, pipe_d;
	rls_word_t hold_a_q, hold_a_d;
	rls_word_t out_a_q, out_a_d, out_b_q, out_b_d;
	rls_word_t dly_a_q [DEPTH], dly_a_d [DEPTH];
	rls_word_t dly_b_q [DEPTH], dly_b_d [DEPTH];
	logic [DEPTH-1:0] dly_v_q, dly_v_d;
	logic phase_b_q, phase_b_d, valid_prev_q, valid_prev_d;
	logic load_q, load_d;
	logic [6:0] clk_a_q, clk_a_d, clk_b_q, clk_b_d;
	logic valid_rise;

	rls_sync2 #(.WIDTH(3)) u_sync_pix (
		.clk_i(clk_pix_i),
		.rstn_i(rstn_i),
		.async_i({pll_locked_o, pixel_mode_select_i, sample_edge_select_i}),
		.sync_o(pix_s)
	);
	assign lock_pix = pix_s[2];
	assign mode_pix = pix_s[1];
	assign edge_pix = pix_s[0];

	// 25 used data bits plus syncs and valid; data bits 20:18 are unused
	assign raw_word = {pixel_data_i[27:21], pixel_valid_flag_i, vertical_sync_i,
		horizontal_sync_i, pixel_data_i[17:0]};

	// falling-edge capture, retimed onto the rising edge below
	always_ff @(negedge clk_pix_i or negedge rstn_i) begin
		if (!rstn_i) fall_q <= '0;
		else fall_q <= raw_word;
	end

	always_comb begin
		cap_d = (edge_pix == `RLS_EDGE_RISING) ? raw_word : fall_q;
		// second stage gives the single path its two-period latency
		pipe_d = cap_q;
		valid_rise = cap_q[`RLS_VALID_POS] && !valid_prev_q;
		valid_prev_d = cap_q[`RLS_VALID_POS];
		// valid rising edge forces this pixel onto set a; blanking must be even
		phase_b_d = valid_rise ? 1'b1 : !phase_b_q;
		hold_a_d = (valid_rise || !phase_b_q) ? cap_q : hold_a_q;
		// pair enters the delay line once set b's pixel is in hand
		dly_a_d[0] = hold_a_q;
		dly_b_d[0] = cap_q;
		dly_v_d[0] = mode_pix && phase_b_q && !valid_rise;
		for (int i = 1; i < DEPTH; i++) begin
			dly_a_d[i] = dly_a_q[i-1];
			dly_b_d[i] = dly_b_q[i-1];
			dly_v_d[i] = dly_v_q[i-1];
		end
		// lane k holds word bits 7k+6:7k, bit 0 sent first
		out_a_d = out_a_q;
		out_b_d = out_b_q;
		load_d = 1'b0;
		clk_a_d = 7'h00;
		clk_b_d = 7'h00;
		if (!lock_pix) begin
			out_a_d = '0;
			out_b_d = '0;
		end else if (mode_pix == `RLS_MODE_SINGLE) begin
			out_a_d = pipe_q;
			out_b_d = '0;
			load_d = 1'b1;
			clk_a_d = `RLS_CLK_PATTERN;
		end else begin
			// each frame stands two pixel clocks, half the rate per set
			load_d = dly_v_q[DEPTH-1];
			if (dly_v_q[DEPTH-1]) begin
				out_a_d = dly_a_q[DEPTH-1];
				out_b_d = dly_b_q[DEPTH-1];
			end
			clk_a_d = `RLS_CLK_PATTERN;
			clk_b_d = `RLS_CLK_PATTERN;
		end
	end

	always_ff @(posedge clk_pix_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hb_pix_q <= 1'b0;
			cap_q <= '0;
			pipe_q <= '0;
			hold_a_q <= '0;
			valid_prev_q <= 1'b0;
			phase_b_q <= 1'b0;
			dly_v_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				dly_a_q[i] <= '0;
				dly_b_q[i] <= '0;
			end
			out_a_q <= '0;
			out_b_q <= '0;
			load_q <= 1'b0;
			clk_a_q <= 7'h00;
			clk_b_q <= 7'h00;
		end else begin
			hb_pix_q <= !hb_pix_q;
			cap_q <= cap_d;
			pipe_q <= pipe_d;
			hold_a_q <= hold_a_d;
			valid_prev_q <= valid_prev_d;
			phase_b_q <= phase_b_d;
			dly_v_q <= dly_v_d;
			for (int i = 0; i < DEPTH; i++) begin
				dly_a_q[i] <= dly_a_d[i];
				dly_b_q[i] <= dly_b_d[i];
			end
			out_a_q <= out_a_d;
			out_b_q <= out_b_d;
			load_q <= load_d;
			clk_a_q <= clk_a_d;
			clk_b_q <= clk_b_d;
		end
	end

	assign lane_set_a_o = out_a_q;
	assign lane_set_b_o = out_b_q;
	assign lane_a_clock_out_o = clk_a_q;
	assign lane_b_clock_out_o = clk_b_q;
	assign frame_load_o = load_q;

	single_load_a: assert property (@(posedge clk_pix_i) disable iff (!rstn_i)
		(lock_pix && !mode_pix) |=> frame_load_o) else $error("single frame missing");
	dual_space_a: assert property (@(posedge clk_pix_i) disable iff (!rstn_i)
		(mode_pix && frame_load_o) |=> !frame_load_o) else $error("dual frames too close");
	clock_shape_a: assert property (@(posedge clk_pix_i) disable iff (!rstn_i)
		frame_load_o |-> lane_a_clock_out_o == 7'h63) else $error("bad clock pattern");
	single_data_a: assert property (@(posedge clk_pix_i) disable iff (!rstn_i)
		(lock_pix && !mode_pix) |=> lane_set_a_o == $past(cap_q, 2))
		else $error("single pixel word wrong");
	dual_latency_a: assert property (@(posedge clk_pix_i) disable iff (!rstn_i)
		(mode_pix && frame_load_o && $past(mode_pix, 9) && $past(lock_pix, 9))
		|-> lane_set_a_o == $past(cap_q, 9) && lane_set_b_o == $past(cap_q, 8))
		else $error("dual pixel latency wrong");
	dark_unlocked_a: assert property (@(posedge clk_pix_i) disable iff (!rstn_i)
		!lock_pix |=> !frame_load_o && lane_set_a_o == '0) else $error("data before lock");
endmodule : rls_serializer
`default_nettype wire

// ==== rls_host_model.sv ====
// host pixel source model: free-running pixel clock and counted pixels
`timescale 1ns/1ps
`default_nettype none
module rls_host_model (
	input wire logic edge_sel_i,
	output logic clk_pix_o,
	output logic [27:0] pixel_data_o,
	output logic hsync_o,
	output logic vsync_o,
	output logic valid_o,
	output int count_o
);
	logic scramble;
	logic [27:0] word_w;
	// 12 ns period sits inside both mode ranges; runs free for the pll
	initial begin
		clk_pix_o = 1'b0;
		forever #6 clk_pix_o = ~clk_pix_o;
	end
	// new pixel just after each rising edge, but only good in the half period
	// around the chosen capture edge; the other half shows its inverse, so a
	// capture on the wrong edge reads garbage
	initial begin
		count_o = 0;
		scramble = 1'b1;
		forever begin
			@(clk_pix_o);
			#1;
			if (clk_pix_o) count_o = count_o + 1;
			scramble = (clk_pix_o == edge_sel_i);
		end
	end
	// ignored bits 20:18 carry a fixed pattern so any leak shows
	assign word_w = {~count_o[6:0], 3'h5, count_o[17:0]};
	assign pixel_data_o = scramble ? ~word_w : word_w;
	assign hsync_o = count_o[0] ^ scramble;
	assign vsync_o = count_o[1] ^ scramble;
	// two blanking pixels in sixteen: even length keeps pairs aligned
	assign valid_o = (count_o[3:1] != 3'h0) ^ scramble;
endmodule : rls_host_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the serializer bridge
`timescale 1ns/1ps
`default_nettype none
`include "rls_regs.svh"
module tb;
	import rls_pkg::*;
	localparam int LOCK = 50;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic mode = 1'b0;
	logic edge_sel = 1'b1;
	logic pd_n = 1'b0;
	logic clk_pix, hsync, vsync, valid, load, en_a, en_b, locked;
	logic [27:0] pix, la, lb;
	logic [6:0] ca, cb;
	int cnt;
	int fails = 0;
	int num_checks = 0;
	// --------------------------------
	// clocks and parts
	// --------------------------------
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	rls_host_model u_rls_host_model (.edge_sel_i(edge_sel), .clk_pix_o(clk_pix),
		.pixel_data_o(pix), .hsync_o(hsync), .vsync_o(vsync), .valid_o(valid),
		.count_o(cnt));
	rls_serializer #(.LOCK_CYCLES(LOCK)) u_rls_serializer (.clk_sys_i(clk_sys),
		.rstn_i(rstn), .clk_pix_i(clk_pix), .pixel_mode_select_i(mode),
		.sample_edge_select_i(edge_sel), .powerdown_active_low_i(pd_n),
		.pixel_data_i(pix), .horizontal_sync_i(hsync), .vertical_sync_i(vsync),
		.pixel_valid_flag_i(valid), .lane_set_a_o(la), .lane_set_b_o(lb),
		.lane_a_clock_out_o(ca), .lane_b_clock_out_o(cb), .frame_load_o(load),
		.lane_a_enable_o(en_a), .lane_b_enable_o(en_b), .pll_locked_o(locked));
	// --------------------------------
	// helpers
	// --------------------------------
	// lane word expected for pixel number n of the host model
	function automatic logic [27:0] word(input int n);
		logic [31:0] u;
		u = n;
		return {~u[6:0], (u[3:1] != 3'h0), u[1], u[0], u[17:0]};
	endfunction : word
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t ns: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// --------------------------------
	// scenarios
	// --------------------------------
	// powerdown low from reset: everything quiet
	task automatic t_reset();
		repeat (10) @(posedge clk_sys);
		#1;
		check(28'({ca, cb, load, en_a, en_b, locked}), 28'h0);
		check(la | lb, 28'h0);
		$display("reset test done");
	endtask : t_reset
	// wake up; lanes must stay empty until lock, lock time bounded
	task automatic t_lock();
		int n;
		n = 0;
		@(posedge clk_sys) #1 pd_n = 1'b1;
		while (locked !== 1'b1 && n < 200) begin
			@(posedge clk_sys) #1 n++;
			check(la | lb, 28'h0);
		end
		check(28'(n >= LOCK && n <= LOCK + 10), 28'h1);
		check(28'({en_a, en_b}), 28'({1'b1, mode}));
		$display("lock test done after %0d cycles", n);
	endtask : t_lock
	// settle after a mode or edge change, then judge every load
	task automatic t_stream(input logic m, input logic e);
		int loads;
		loads = 0;
		@(posedge clk_sys) #1 mode = m;
		edge_sel = e;
		repeat (40) @(negedge clk_pix);
		repeat (48) begin
			@(negedge clk_pix);
			if (load === 1'b1) begin
				loads++;
				if (m) begin
					check(28'(cnt[0]), 28'h0);
					check(la, word(cnt - 10));
					check(lb, word(cnt - 9));
				end else begin
					check(la, word(cnt - 3));
					check(lb, 28'h0);
				end
				check(28'(ca), 28'(`RLS_CLK_PATTERN));
				check(28'(cb), 28'(m ? `RLS_CLK_PATTERN : 7'h00));
			end
		end
		check(28'(loads), m ? 28'h18 : 28'h30);
		check(28'({en_a, en_b}), 28'({1'b1, m}));
		$display("stream test mode %0d edge %0d done", m, e);
	endtask : t_stream
	// sleep: drivers off in bounded time, lanes emptied
	task automatic t_down();
		int n;
		n = 0;
		@(posedge clk_sys) #1 pd_n = 1'b0;
		while (en_a !== 1'b0 && n < 20) begin
			@(posedge clk_sys) #1 n++;
		end
		check(28'(n <= `RLS_PD_DELAY_CYCLES), 28'h1);
		check(28'({en_a, en_b, locked}), 28'h0);
		repeat (20) @(negedge clk_pix);
		check(la | lb, 28'h0);
		check(28'(load), 28'h0);
		$display("powerdown test done");
	endtask : t_down
	// --------------------------------
	// main sequence and watchdog
	// --------------------------------
	initial begin
		repeat (5) @(posedge clk_sys);
		#1 rstn = 1'b1;
		t_reset();
		t_lock();
		t_stream(1'b0, 1'b1);
		t_stream(1'b0, 1'b0);
		t_stream(1'b1, 1'b1);
		t_stream(1'b1, 1'b0);
		t_down();
		t_lock();
		t_stream(1'b1, 1'b1);
		end_sim();
	end
	// whole run needs about 7 us; a hang is cut off well past that
	initial begin
		#100000;
		fails++;
		end_sim();
	end
endmodule : tb
`default_nettype wire
